//--- src/ecsr_pkg.sv
// constants for the configuration save/restore controller
package ecsr_pkg;
  // register offsets on the serial control port
  localparam logic [11:0] OFS_BUSY    = 12'hB00;
  localparam logic [11:0] OFS_ERROR   = 12'hB01;
  localparam logic [11:0] OFS_CTRL    = 12'hB02;
  localparam logic [11:0] OFS_SAVE    = 12'hB03;
  localparam logic [11:0] OFS_COMMIT  = 12'h232;
  localparam logic [3:0]  SEG_PAGE    = 4'hA;    // 0xA00..0xAFF holds the command list

  // field positions
  localparam int BIT_BUSY    = 0;
  localparam int BIT_ERROR   = 0;
  localparam int BIT_PERMIT  = 0;
  localparam int BIT_RELOAD  = 1;
  localparam int BIT_SAVE    = 0;
  localparam int BIT_COMMIT  = 0;
  localparam int BIT_OPCODE  = 7;

  // reset values
  localparam logic RST_PERMIT = 1'b0;
  localparam logic RST_SAVE   = 1'b0;

  // operation codes in the command list
  localparam logic [7:0] OP_COMMIT = 8'h80;
  localparam logic [7:0] OP_END    = 8'hFF;

  // default command list: one 128-byte transfer from 0x0000, commit, end
  localparam int         DEF_LEN   = 5;
  localparam logic [7:0] DEF_CMD   = 8'h7F;
  localparam logic [7:0] DEF_A_HI  = 8'h00;
  localparam logic [7:0] DEF_A_LO  = 8'h00;

  // least gap between two transfers
  localparam int CLK_MHZ     = 50;
  localparam int T_GAP_NS    = 10000;
  localparam int GAP_CYCLES  = (T_GAP_NS * CLK_MHZ + 999) / 1000;

  // sequencer states, gray on each step except DECODE to NVM or SUM, BWR to SEGW and DONE to IDLE
  typedef enum logic [3:0] {
    ST_INIT   = 4'h0,
    ST_IDLE   = 4'h1,
    ST_SEGW   = 4'h3,
    ST_DECODE = 4'h2,
    ST_BANK   = 4'h6,
    ST_BANKW  = 4'h7,
    ST_NVM    = 4'h5,
    ST_BWR    = 4'h4,
    ST_SUM    = 4'hC,
    ST_DONE   = 4'hD
  } ecsr_state_t;

  // what the pending command-list byte is
  typedef enum logic [1:0] {
    SEG_CMD  = 2'h0,
    SEG_A_HI = 2'h1,
    SEG_A_LO = 2'h3
  } ecsr_seg_t;
endpackage

//--- src/ecsr_seg_mem.sv
// command-list memory with registered read data
`timescale 1ns/1ps
module ecsr_seg_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock
  input  wire logic          clk_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write and registered read
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

//--- src/ecsr_ctrl.sv
// configuration save/restore controller between register bank and store
`timescale 1ns/1ps
module ecsr_ctrl #(
  parameter int NVM_AW = 10
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // register port
  input  wire logic [11:0]       reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  output logic                   reg_rvalid_o,
  // pins
  input  wire logic              nvm_sel_n_i,
  input  wire logic              status_pin_sel_i,
  input  wire logic              status_other_i,
  output logic                   status_o,
  // buffer register bank
  output logic      [15:0]       bank_addr_o,
  output logic                   bank_rd_o,
  output logic                   bank_we_o,
  output logic      [7:0]        bank_wdata_o,
  input  wire logic [7:0]        bank_rdata_i,
  // nonvolatile store
  output logic                   nvm_req_o,
  output logic                   nvm_we_o,
  output logic      [NVM_AW-1:0] nvm_addr_o,
  output logic      [7:0]        nvm_wdata_o,
  input  wire logic              nvm_ack_i,
  input  wire logic [7:0]        nvm_rdata_i,
  // device-wide effects
  output logic                   commit_o,
  output logic                   soft_rst_o
);
  ecsr_pkg::ecsr_state_t state;
  ecsr_pkg::ecsr_seg_t   seg_what;
  logic [7:0]        ptr;
  logic [6:0]        cnt;
  logic [15:0]       baddr;
  logic [NVM_AW-1:0] nptr;
  logic [7:0]        sum;
  logic [7:0]        data;
  logic              is_save;
  logic              busy;
  logic              err;
  logic              permit;
  logic              save_trig;
  logic [1:0]        sel_sync;
  logic [9:0]        gap;
  logic [7:0]        seg_rdata;
  logic              seg_we;
  logic [7:0]        seg_waddr;
  logic [7:0]        seg_wdata;
  logic              rd_d;
  logic [11:0]       raddr_d;
  logic              start_save;
  logic              start_load;
  logic              host_seg_wr;

  // true when the address falls inside the command-list page
  function automatic logic in_seg(input logic [11:0] a);
    in_seg = (a[11:8] == ecsr_pkg::SEG_PAGE);
  endfunction

  // default command list contents
  function automatic logic [7:0] def_byte(input logic [7:0] i);
    case (i)
      8'h00:   def_byte = ecsr_pkg::DEF_CMD;
      8'h01:   def_byte = ecsr_pkg::DEF_A_HI;
      8'h02:   def_byte = ecsr_pkg::DEF_A_LO;
      8'h03:   def_byte = ecsr_pkg::OP_COMMIT;
      default: def_byte = ecsr_pkg::OP_END;
    endcase
  endfunction

  // nonvolatile-select pin through two flip-flops
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sel_sync <= 2'h3;                                                            // idle high: no false reload
    else
      sel_sync <= {sel_sync[0], nvm_sel_n_i};
  end

  assign busy        = (state != ecsr_pkg::ST_IDLE) && (state != ecsr_pkg::ST_INIT);
  assign host_seg_wr = reg_wr_i && in_seg(reg_addr_i) && !busy && (state != ecsr_pkg::ST_INIT);
  // a save or reload is taken only when idle and the gap has run out
  assign start_save  = (state == ecsr_pkg::ST_IDLE) && (gap == 10'h000) && save_trig;
  assign start_load  = reg_wr_i && (reg_addr_i == ecsr_pkg::OFS_CTRL) && reg_wdata_i[ecsr_pkg::BIT_RELOAD]
                       && !sel_sync[1] && (state == ecsr_pkg::ST_IDLE) && (gap == 10'h000);

  // command-list memory: filled with defaults after reset, then host writes while idle
  assign seg_we    = (state == ecsr_pkg::ST_INIT) || host_seg_wr;
  assign seg_waddr = (state == ecsr_pkg::ST_INIT) ? ptr : reg_addr_i[7:0];
  assign seg_wdata = (state == ecsr_pkg::ST_INIT) ? def_byte(ptr) : reg_wdata_i;

  ecsr_seg_mem #(
    .AW (8),
    .DW (8)
  ) u_seg (
    .clk_i   (clk_i),
    .we_i    (seg_we),
    .waddr_i (seg_waddr),
    .wdata_i (seg_wdata),
    .raddr_i (busy ? ptr : reg_addr_i[7:0]),
    .rdata_o (seg_rdata)
  );

  // write permit, reset to protected
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      permit <= ecsr_pkg::RST_PERMIT;
    else if (reg_wr_i && reg_addr_i == ecsr_pkg::OFS_CTRL)
      permit <= reg_wdata_i[ecsr_pkg::BIT_PERMIT];
  end

  // save trigger: software sets, sequencer clears at the end of the save or when the save is refused without permit
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      save_trig <= ecsr_pkg::RST_SAVE;
    else if (reg_wr_i && reg_addr_i == ecsr_pkg::OFS_SAVE && reg_wdata_i[ecsr_pkg::BIT_SAVE])
      save_trig <= 1'b1;
    else if (state == ecsr_pkg::ST_IDLE && save_trig && gap == 10'h000 && !permit)
      save_trig <= 1'b0;
    else if (state == ecsr_pkg::ST_DONE && is_save)
      save_trig <= 1'b0;
  end

  // guard time after each transfer
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gap <= 10'h000;
    else if (state == ecsr_pkg::ST_DONE)
      gap <= 10'(ecsr_pkg::GAP_CYCLES);
    else if (gap != 10'h000)
      gap <= gap - 10'h001;
  end

  // commit pulse from the commit register or a commit opcode
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      commit_o <= 1'b0;
    else
      commit_o <= (reg_wr_i && reg_addr_i == ecsr_pkg::OFS_COMMIT && reg_wdata_i[ecsr_pkg::BIT_COMMIT])
                  || (state == ecsr_pkg::ST_DECODE && seg_what == ecsr_pkg::SEG_CMD
                      && seg_rdata == ecsr_pkg::OP_COMMIT);
  end

  // soft reset pulse at the start of a reload
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      soft_rst_o <= 1'b0;
    else
      soft_rst_o <= start_load;
  end

  // error flag: cleared at each start, set on a bad checksum or a list with no end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      err <= 1'b0;
    else if (state == ecsr_pkg::ST_SUM && !is_save && nvm_ack_i && nvm_rdata_i != sum)
      err <= 1'b1;
    else if (state == ecsr_pkg::ST_DECODE && ptr == 8'hFF && seg_what == ecsr_pkg::SEG_CMD
             && seg_rdata != ecsr_pkg::OP_END && seg_rdata != ecsr_pkg::OP_COMMIT)
      err <= 1'b1;
    else if (start_save && permit || start_load)
      err <= 1'b0;
  end

  // sequencer walking the command list
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state    <= ecsr_pkg::ST_INIT;
      seg_what <= ecsr_pkg::SEG_CMD;
      ptr      <= 8'h00;
      cnt      <= 7'h00;
      baddr    <= 16'h0000;
      nptr     <= '0;
      sum      <= 8'h00;
      data     <= 8'h00;
      is_save  <= 1'b0;
    end
    else
    begin
      case (state)
        ecsr_pkg::ST_INIT:
        begin
          ptr <= ptr + 8'h01;
          if (ptr == 8'(ecsr_pkg::DEF_LEN - 1))
          begin
            state <= ecsr_pkg::ST_IDLE;
          end
        end
        ecsr_pkg::ST_IDLE:
        begin
          ptr      <= 8'h00;
          nptr     <= '0;
          sum      <= 8'h00;
          seg_what <= ecsr_pkg::SEG_CMD;
          if ((start_save && permit) || start_load)
          begin
            is_save <= start_save;
            state   <= ecsr_pkg::ST_SEGW;
          end
        end
        ecsr_pkg::ST_SEGW:
          state <= ecsr_pkg::ST_DECODE;
        ecsr_pkg::ST_DECODE:
        begin
          ptr   <= ptr + 8'h01;
          state <= ecsr_pkg::ST_SEGW;
          case (seg_what)
            ecsr_pkg::SEG_CMD:
            begin
              if (!seg_rdata[ecsr_pkg::BIT_OPCODE])
              begin
                cnt      <= seg_rdata[6:0];
                seg_what <= ecsr_pkg::SEG_A_HI;
              end
              else if (seg_rdata == ecsr_pkg::OP_END || ptr == 8'hFF)
              begin
                state <= ecsr_pkg::ST_SUM;
              end
            end
            ecsr_pkg::SEG_A_HI:
            begin
              baddr[15:8] <= seg_rdata;
              seg_what    <= ecsr_pkg::SEG_A_LO;
            end
            default:
            begin
              baddr[7:0] <= seg_rdata;
              seg_what   <= ecsr_pkg::SEG_CMD;
              state      <= is_save ? ecsr_pkg::ST_BANK : ecsr_pkg::ST_NVM;
            end
          endcase
        end
        ecsr_pkg::ST_BANK:
          state <= ecsr_pkg::ST_BANKW;
        ecsr_pkg::ST_BANKW:
        begin
          data  <= bank_rdata_i;
          state <= ecsr_pkg::ST_NVM;
        end
        ecsr_pkg::ST_NVM:
        begin
          if (nvm_ack_i)
          begin
            nptr <= nptr + 1'b1;
            if (is_save)
            begin
              sum <= sum + data;
            end
            else
            begin
              data <= nvm_rdata_i;
              sum  <= sum + nvm_rdata_i;
            end
            state <= is_save ? ecsr_pkg::ST_BWR : ecsr_pkg::ST_BWR;
          end
        end
        ecsr_pkg::ST_BWR:
        begin
          baddr <= baddr + 16'h0001;
          cnt   <= cnt - 7'h01;
          if (cnt == 7'h00)
            state <= ecsr_pkg::ST_SEGW;
          else
            state <= is_save ? ecsr_pkg::ST_BANK : ecsr_pkg::ST_NVM;
        end
        ecsr_pkg::ST_SUM:
        begin
          if (nvm_ack_i)
          begin
            state <= ecsr_pkg::ST_DONE;
          end
        end
        ecsr_pkg::ST_DONE:
          state <= ecsr_pkg::ST_IDLE;
        default:
          state <= ecsr_pkg::ST_IDLE;
      endcase
    end
  end

  // bank port: read on a save, write on a load
  assign bank_addr_o  = baddr;
  assign bank_rd_o    = (state == ecsr_pkg::ST_BANK);
  assign bank_we_o    = (state == ecsr_pkg::ST_BWR) && !is_save;
  assign bank_wdata_o = data;

  // store port: request held until acknowledged, checksum byte last
  assign nvm_req_o   = (state == ecsr_pkg::ST_NVM) || (state == ecsr_pkg::ST_SUM);
  assign nvm_we_o    = nvm_req_o && is_save;
  assign nvm_addr_o  = nptr;
  assign nvm_wdata_o = (state == ecsr_pkg::ST_SUM) ? sum : data;

  // status pin mirrors busy when selected
  assign status_o = status_pin_sel_i ? busy : status_other_i;

  // register reads answer two cycles after the strobe
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_d         <= 1'b0;
      raddr_d      <= 12'h000;
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      rd_d         <= reg_rd_i;
      raddr_d      <= reg_addr_i;
      reg_rvalid_o <= rd_d;
      if (rd_d)
      begin
        case (raddr_d)
          ecsr_pkg::OFS_BUSY:  reg_rdata_o <= {7'h00, busy};
          ecsr_pkg::OFS_ERROR: reg_rdata_o <= {7'h00, err};
          ecsr_pkg::OFS_CTRL:  reg_rdata_o <= {7'h00, permit};
          ecsr_pkg::OFS_SAVE:  reg_rdata_o <= {7'h00, save_trig};
          default:             reg_rdata_o <= in_seg(raddr_d) ? seg_rdata : 8'h00;
        endcase
      end
    end
  end
endmodule

//--- tb/ecsr_ctrl_sva.sv
// assertion checker for the save/restore controller ports
`timescale 1ns/1ps
module ecsr_ctrl_chk #(
  parameter int NVM_AW = 10
) (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  // register port
  input wire logic [11:0]       reg_addr_i,
  input wire logic              reg_wr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              reg_rvalid_o,
  // pins, store and effects
  input wire logic              status_pin_sel_i,
  input wire logic              status_other_i,
  input wire logic              status_o,
  input wire logic              nvm_req_o,
  input wire logic              nvm_we_o,
  input wire logic [NVM_AW-1:0] nvm_addr_o,
  input wire logic              nvm_ack_i,
  input wire logic              commit_o,
  input wire logic              soft_rst_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic permit_q;
  // follows the write-permit bit as software last wrote it
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i) permit_q <= 1'b0;
    else if (reg_wr_i && reg_addr_i == ecsr_pkg::OFS_CTRL) permit_q <= reg_wdata_i[0];
  // register steps
  sequence s_commit_wr;
    reg_wr_i && reg_addr_i == ecsr_pkg::OFS_COMMIT && reg_wdata_i[0];
  endsequence
  sequence s_rd_done(logic [11:0] a);
    reg_rvalid_o && $past(reg_rd_i, 2) && $past(reg_addr_i, 2) == a;
  endsequence
  a_commit_pulse: assert property (s_commit_wr |=> commit_o)
    else $error("commit pulse missing");
  a_read_latency: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
    else $error("read answer late");
  a_ctrl_bits: assert property (s_rd_done(ecsr_pkg::OFS_CTRL) |-> reg_rdata_o[7:1] == 7'h00)
    else $error("control byte upper bits set");
  a_unused_bits: assert property ((s_rd_done(ecsr_pkg::OFS_BUSY) or s_rd_done(ecsr_pkg::OFS_ERROR)
    or s_rd_done(ecsr_pkg::OFS_SAVE)) |-> reg_rdata_o[7:1] == 7'h00) else $error("unused bits set");
  a_busy_read: assert property (s_rd_done(ecsr_pkg::OFS_BUSY) ##0 $past(nvm_req_o)
    |-> reg_rdata_o[0]) else $error("busy bit low during transfer");
  a_busy_pin: assert property (s_rd_done(ecsr_pkg::OFS_BUSY) ##0 $past(status_pin_sel_i)
    |-> reg_rdata_o[0] == $past(status_o)) else $error("busy bit and status pin differ");
  a_pin_busy: assert property (status_pin_sel_i && nvm_req_o |-> status_o)
    else $error("status pin not showing busy");
  a_pin_other: assert property (!status_pin_sel_i |-> status_o == status_other_i)
    else $error("status pin wrong source");
  a_no_protected: assert property (!permit_q |-> !(nvm_req_o && nvm_we_o))
    else $error("store written while protected");
  a_req_hold: assert property (nvm_req_o && !nvm_ack_i |=>
    nvm_req_o && $stable(nvm_addr_o) && $stable(nvm_we_o)) else $error("store request dropped early");
  a_reload_load: assert property (soft_rst_o |=> !soft_rst_o ##[0:40] (nvm_req_o && !nvm_we_o))
    else $error("reload did not load");
endmodule
bind ecsr_ctrl ecsr_ctrl_chk #(.NVM_AW(NVM_AW)) ecsr_ctrl_chk_inst (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .status_pin_sel_i, .status_other_i, .status_o, .nvm_req_o,
  .nvm_we_o, .nvm_addr_o, .nvm_ack_i, .commit_o, .soft_rst_o);

//--- tb/ecsr_store_model.sv
// behavioural model of the in-package configuration store
`timescale 1ns/1ps
module ecsr_store_model #(
  parameter int AW = 10
) (
  // clock and pace
  input  wire logic          clk_i,
  input  wire logic          slow_i,
  // request side
  input  wire logic          req_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  // answer side
  output logic               ack_o = 1'b0,
  output logic      [7:0]    rdata_o = 8'h00
);
  logic [7:0] mem [2**AW];
  logic [2:0] wait_q = 3'h0;
  // answers after one or five cycles, then skips a cycle
  always @(posedge clk_i)
    if (ack_o)
    begin
      ack_o   <= 1'b0;
      wait_q  <= 3'h0;
      rdata_o <= ~rdata_o;
    end
    else if (req_i && wait_q == (slow_i ? 3'h4 : 3'h0))
    begin
      ack_o   <= 1'b1;
      rdata_o <= mem[addr_i];
      if (we_i) mem[addr_i] <= wdata_i;
    end
    else
    begin
      wait_q  <= req_i ? wait_q + 3'h1 : 3'h0;
      rdata_o <= ~rdata_o; // released data never holds
    end
endmodule

//--- tb/test_eeprom_config_save_restore.sv
// self-checking bench for the save/restore controller
`timescale 1ns/1ps
`define CHK(N, E, G) begin n_checks++; if ((E) !== (G)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", N, E, G); end end
module test_eeprom_config_save_restore;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, nvm_sel_n_i = 1'b1;
  logic        status_pin_sel_i = 1'b0, status_other_i = 1'b1, slow = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, bank_wdata_o, bank_rdata_i = 8'h00, nvm_wdata_o, nvm_rdata_i, e, m;
  logic        reg_rvalid_o, status_o, bank_rd_o, bank_we_o, nvm_req_o, nvm_we_o, nvm_ack_i, commit_o, soft_rst_o;
  logic [15:0] bank_addr_o;
  logic [9:0]  nvm_addr_o;
  logic [7:0]  bank [256];
  logic [7:0]  exp_q [$], msk_q [$];
  logic [11:0] regs [5] = '{ecsr_pkg::OFS_BUSY, ecsr_pkg::OFS_ERROR, ecsr_pkg::OFS_CTRL, ecsr_pkg::OFS_SAVE, 12'h7FF};
  int          fail_count = 0, n_checks = 0, cycles = 0, commit_n = 0, soft_n = 0, i;
  ecsr_ctrl #(.NVM_AW(10)) ecsr_ctrl_inst (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .reg_rvalid_o, .nvm_sel_n_i, .status_pin_sel_i, .status_other_i, .status_o, .bank_addr_o,
    .bank_rd_o, .bank_we_o, .bank_wdata_o, .bank_rdata_i, .nvm_req_o, .nvm_we_o, .nvm_addr_o, .nvm_wdata_o,
    .nvm_ack_i, .nvm_rdata_i, .commit_o, .soft_rst_o);
  ecsr_store_model #(.AW(10)) ecsr_store_model_inst (.clk_i, .slow_i(slow), .req_i(nvm_req_o), .we_i(nvm_we_o),
    .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .ack_o(nvm_ack_i), .rdata_o(nvm_rdata_i));
  always #10 clk_i = ~clk_i;
  // buffer bank, pulse counters and the hang limit
  always @(posedge clk_i)
  begin
    bank_rdata_i <= bank_rd_o ? bank[bank_addr_o[7:0]] : ~bank_rdata_i;
    if (bank_we_o) bank[bank_addr_o[7:0]] <= bank_wdata_o;
    commit_n += int'(commit_o === 1'b1);
    soft_n   += int'(soft_rst_o === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // compares each read answer with the oldest noted expectation
  always @(negedge clk_i)
    if (reg_rvalid_o === 1'b1)
    begin
      `CHK("pending reads", 1'b1, exp_q.size() > 0)
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK("read data", e, reg_rdata_o & m)
    end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cyc(1);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] k);
    cyc(1);
    exp_q.push_back(x);
    msk_q.push_back(k);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
  endtask
  // waits for busy on the pin, reads it, then waits out the gap
  task automatic wait_xfer();
    repeat (20) if (status_o !== 1'b1) cyc(1);
    `CHK("busy pin", 1'b1, status_o)
    rd(ecsr_pkg::OFS_BUSY, 8'h01, 8'hFF);
    while (status_o === 1'b1) cyc(1);
    rd(ecsr_pkg::OFS_BUSY, 8'h00, 8'hFF);
    cyc(520);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h4DDC5ADC));
    cyc(20);
    sys_rst_i = 1'b0;
    cyc(520);
    for (i = 0; i < 5; i++) rd(regs[i], 8'h00, 8'hFF);
    rd(12'hA00, ecsr_pkg::DEF_CMD, 8'hFF);
    rd(12'hA03, ecsr_pkg::OP_COMMIT, 8'hFF);
    status_other_i = 1'($urandom);
    cyc(1);
    `CHK("pin other", status_other_i, status_o)
    wr(ecsr_pkg::OFS_SAVE, 8'h01);
    cyc(520);
    rd(ecsr_pkg::OFS_SAVE, 8'h00, 8'hFF);
    for (i = 0; i < 256; i++) bank[i] = 8'($urandom);
    status_pin_sel_i = 1'b1;
    wr(ecsr_pkg::OFS_CTRL, 8'h01);
    rd(ecsr_pkg::OFS_CTRL, 8'h01, 8'hFF);
    wr(ecsr_pkg::OFS_SAVE, 8'h01);
    wait_xfer();
    for (i = 0; i < 128; i++) `CHK("stored byte", bank[i], ecsr_store_model_inst.mem[i])
    `CHK("save commits", 1, commit_n)
    rd(ecsr_pkg::OFS_SAVE, 8'h00, 8'hFF);
    rd(ecsr_pkg::OFS_ERROR, 8'h00, 8'hFF);
    ecsr_store_model_inst.mem[5] = ecsr_store_model_inst.mem[5] ^ 8'h10;
    for (i = 0; i < 256; i++) bank[i] = 8'($urandom);
    slow = 1'b1;
    wr(ecsr_pkg::OFS_CTRL, 8'h03);
    cyc(520);
    `CHK("reload with pin high", 0, soft_n)
    nvm_sel_n_i = 1'b0;
    cyc(4);
    wr(ecsr_pkg::OFS_CTRL, 8'h03);
    wait_xfer();
    `CHK("soft reset pulses", 1, soft_n)
    `CHK("load commits", 2, commit_n)
    for (i = 0; i < 128; i++) `CHK("loaded byte", ecsr_store_model_inst.mem[i], bank[i])
    rd(ecsr_pkg::OFS_ERROR, 8'h01, 8'hFF);
    rd(ecsr_pkg::OFS_CTRL, 8'h00, 8'h02);
    wr(ecsr_pkg::OFS_COMMIT, 8'h01);
    cyc(3);
    `CHK("direct commit", 3, commit_n)
    `CHK("reads answered", 0, exp_q.size())
    stop_test();
  end
endmodule
